/* hdl/msc_scan_control.v */
// Overview of operation
// - IIR amend set means results are added into accumulators at sequence end.
// - IIR amend clear leaves accumulators untouched at sequence end.
// - Balancing scans always amend the accumulators.
// - Read-filter select picks filtered or raw data for result registers.
// - Read-filter select is captured when a measurement request is accepted.
// - Comparator scans are unipolar and skip bipolar cell measurements.
// - Calibration scans update correction coefficients only.
// - Balancing scans always run ADC-only.
// - Oversampling field selects averaged acquisitions per channel.
// - Oversampling ignored in calibration; balancing forces sixteen times.
// - Path select picks primary or alternate path; diagnostics prevail.
// - Order select picks pyramid or ramp; comparator and calibration use pyramid.
// - Balancing scans always use pyramid ordering.
// - Request bit is a self-clearing strobe and reads zero.
// - Write with request set starts a scan and a result transfer.
// - Write with request clear transfers data and applies configuration only.
// - Request while busy or complete stores bits 12:1 and raises reject alert.
// - Completion flag sets on scan end; write zero clears, one is ignored.
//
// The register addresses and the APB register port were chosen for this implementation.
`include "msc_defines.vh"

module msc_scan_control (
  // Clock and reset.
  input  wire        mclk_in,
  input  wire        resetn_in,
  // APB slave.
  input  wire        psel_in,
  input  wire        penable_in,
  input  wire        pwrite_in,
  input  wire [11:0] paddr_in,
  input  wire [31:0] pwdata_in,
  output wire        pready_out,
  output reg  [31:0] prdata_out,
  output wire        pslverr_out,
  // Acquisition engine status.
  input  wire        scan_busy_in,
  input  wire        scan_end_in,
  input  wire        scan_timeout_in,
  input  wire        data_moved_in,
  input  wire        balance_scan_in,
  // Acquisition engine control.
  output reg         scan_start_out,
  output reg         data_transfer_out,
  output reg  [2:0]  eff_type_out,
  output reg  [2:0]  eff_ovs_out,
  output reg         eff_alt_path_out,
  output reg         eff_ramp_out,
  output reg         eff_amend_out,
  output reg         amend_strobe_out,
  output reg         comp_unipolar_out,
  output reg         cal_only_out,
  output reg         read_filtered_select_latched_out,
  output wire        read_filtered_select_live_out,
  output wire        alert_filt_out,
  output wire        autobal_dis_out,
  output reg         request_rejected_alert_out
);

  ////////////////////////////////////////////////////////////////////////////
  reg  [15:0] ctrl;
  reg         amend_cur;
  wire        wr_ok;
  wire        rd_ok;
  wire        wr_ctrl;
  wire        wr_stat;
  wire [15:0] wdat;
  wire        req_bit;
  wire        accept;
  wire        reject;
  wire [2:0]  prog_type;
  wire        diag_type;

  function is_diag;
    input [2:0] t;
    begin
      is_diag = t[2];
    end
  endfunction

  assign pready_out  = 1'b1;
  assign wr_ok       = psel_in & penable_in & pwrite_in;
  assign rd_ok       = psel_in & penable_in & ~pwrite_in;
  assign pslverr_out = psel_in & penable_in &
                       (paddr_in != `MSC_ADDR_CTRL) &
                       (paddr_in != `MSC_ADDR_STAT);
  assign wr_ctrl     = wr_ok & (paddr_in == `MSC_ADDR_CTRL);
  assign wr_stat     = wr_ok & (paddr_in == `MSC_ADDR_STAT);
  assign wdat        = pwdata_in[15:0];
  assign req_bit     = wdat[`MSC_BIT_REQUEST];
  // A request is refused while a scan runs or completion is pending.
  assign reject      = wr_ctrl & req_bit &
                       (scan_busy_in | ctrl[`MSC_BIT_DONE]);
  assign accept      = wr_ctrl & req_bit & ~reject;
  assign prog_type   = ctrl[`MSC_TYPE_HI:`MSC_TYPE_LO];
  assign diag_type   = is_diag(prog_type);

  assign read_filtered_select_live_out = ctrl[`MSC_BIT_READ_FILTERED_SELECT];
  assign alert_filt_out  = ctrl[`MSC_BIT_ALRTFILT] | balance_scan_in;
  assign autobal_dis_out = ctrl[`MSC_BIT_AUTOBAL];

  ////////////////////////////////////////////////////////////////////////////
  // Control register; hardware sets of the flags win over software clears.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      ctrl <= `MSC_CTRL_RESET;
    end else begin
      if (wr_ctrl) begin
        ctrl[12:1] <= wdat[12:1];
        ctrl[`MSC_BIT_REQUEST] <= 1'b0;
        if (!wdat[`MSC_BIT_DONE])
          ctrl[`MSC_BIT_DONE] <= 1'b0;
        if (!wdat[`MSC_BIT_TIMEOUT])
          ctrl[`MSC_BIT_TIMEOUT] <= 1'b0;
        if (!wdat[`MSC_BIT_READY])
          ctrl[`MSC_BIT_READY] <= 1'b0;
      end
      if (scan_end_in)
        ctrl[`MSC_BIT_DONE] <= 1'b1;
      if (scan_timeout_in)
        ctrl[`MSC_BIT_TIMEOUT] <= 1'b1;
      if (data_moved_in)
        ctrl[`MSC_BIT_READY] <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Strobes toward the acquisition engine.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      scan_start_out             <= 1'b0;
      data_transfer_out          <= 1'b0;
      request_rejected_alert_out <= 1'b0;
      read_filtered_select_latched_out         <= 1'b0;
      amend_strobe_out           <= 1'b0;
      amend_cur                  <= 1'b0;
    end else begin
      scan_start_out             <= accept;
      data_transfer_out          <= wr_ctrl;
      request_rejected_alert_out <= reject;
      if (accept) begin
        read_filtered_select_latched_out <= wdat[`MSC_BIT_READ_FILTERED_SELECT];
        amend_cur <= wdat[`MSC_BIT_AMEND] | balance_scan_in;
      end
      amend_strobe_out <= scan_end_in & amend_cur;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Effective scan settings after balancing and type overrides.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      eff_type_out      <= `MSC_TYPE_ADC;
      eff_ovs_out       <= `MSC_OVS_SINGLE;
      eff_alt_path_out  <= 1'b0;
      eff_ramp_out      <= 1'b0;
      eff_amend_out     <= 1'b0;
      comp_unipolar_out <= 1'b0;
      cal_only_out      <= 1'b0;
    end else if (balance_scan_in) begin
      eff_type_out      <= `MSC_TYPE_ADC;
      eff_ovs_out       <= `MSC_OVS_BALANCE;
      eff_alt_path_out  <= ctrl[`MSC_BIT_ALTPATH];
      eff_ramp_out      <= 1'b0;
      eff_amend_out     <= 1'b1;
      comp_unipolar_out <= 1'b0;
      cal_only_out      <= 1'b0;
    end else begin
      eff_type_out  <= prog_type;
      eff_amend_out <= ctrl[`MSC_BIT_AMEND];
      // Switch-diagnostic types drive the path themselves.
      eff_alt_path_out <= diag_type ? 1'b0
                                    : ctrl[`MSC_BIT_ALTPATH];
      case (prog_type)
        `MSC_TYPE_CAL: begin
          eff_ovs_out       <= `MSC_OVS_SINGLE;
          eff_ramp_out      <= 1'b0;
          comp_unipolar_out <= 1'b0;
          cal_only_out      <= 1'b1;
        end
        `MSC_TYPE_ADC_COMP, `MSC_TYPE_COMP: begin
          eff_ovs_out       <= ctrl[`MSC_OVS_HI:`MSC_OVS_LO];
          eff_ramp_out      <= 1'b0;
          comp_unipolar_out <= 1'b1;
          cal_only_out      <= 1'b0;
        end
        default: begin
          eff_ovs_out       <= ctrl[`MSC_OVS_HI:`MSC_OVS_LO];
          eff_ramp_out      <= ctrl[`MSC_BIT_ORDER];
          comp_unipolar_out <= 1'b0;
          cal_only_out      <= 1'b0;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Read data; the request bit always reads zero.
  always @(posedge mclk_in) begin
    if (!resetn_in) begin
      prdata_out <= 32'h00000000;
    end else if (psel_in & ~penable_in & ~pwrite_in) begin
      if (paddr_in == `MSC_ADDR_CTRL)
        prdata_out <= {16'h0000, ctrl[15:1], 1'b0};
      else if (paddr_in == `MSC_ADDR_STAT)
        prdata_out <= {26'h0000000, amend_cur, read_filtered_select_latched_out,
                       cal_only_out, comp_unipolar_out, eff_ramp_out,
                       scan_busy_in};
      else
        prdata_out <= 32'h00000000;
    end
  end

  // The status word is read-only; writes to it are accepted and dropped.
  wire unused_ok = rd_ok | wr_stat;

endmodule // msc_scan_control

/* hdl/msc_defines.vh */
`ifndef MSC_DEFINES_VH
`define MSC_DEFINES_VH
// Register indices; each register is one word, so the byte address is four
// times the index.
`define MSC_IDX_CTRL       12'h066
`define MSC_IDX_STAT       12'h06c
`define MSC_ADDR_CTRL      12'h198
`define MSC_ADDR_STAT      12'h1b0
// Control register fields.
`define MSC_BIT_DONE       15
`define MSC_BIT_TIMEOUT    14
`define MSC_BIT_READY      13
`define MSC_BIT_AUTOBAL    12
`define MSC_BIT_ALRTFILT   11
`define MSC_BIT_AMEND      10
`define MSC_BIT_READ_FILTERED_SELECT     9
`define MSC_TYPE_HI        8
`define MSC_TYPE_LO        6
`define MSC_OVS_HI         5
`define MSC_OVS_LO         3
`define MSC_BIT_ALTPATH    2
`define MSC_BIT_ORDER      1
`define MSC_BIT_REQUEST    0
`define MSC_CTRL_RESET     16'h0000
`define MSC_WRITE_MASK     16'h1ffe
// Scan type encodings.
`define MSC_TYPE_ADC       3'h0
`define MSC_TYPE_ADC_COMP  3'h1
`define MSC_TYPE_COMP      3'h2
`define MSC_TYPE_CAL       3'h3
`define MSC_TYPE_SW_SHORT  3'h4
`define MSC_TYPE_SW_OPEN   3'h5
`define MSC_TYPE_ODD_OPEN  3'h6
`define MSC_TYPE_EVEN_OPEN 3'h7
// Oversampling codes.
`define MSC_OVS_BALANCE    3'h3
`define MSC_OVS_SINGLE     3'h0
`endif

/* verification/msc_scan_control_asserts.sv */
`include "msc_defines.vh"
module msc_asserts (
  input logic        mclk_in, resetn_in, psel_in, penable_in, pwrite_in,
  input logic [11:0] paddr_in,
  input logic [31:0] pwdata_in, prdata_out,
  input logic        scan_busy_in, scan_end_in, balance_scan_in,
  input logic        scan_start_out, request_rejected_alert_out,
  input logic        data_transfer_out, eff_ramp_out, amend_strobe_out,
  input logic [2:0]  eff_type_out, eff_ovs_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic done_q;
  wire  wr_c = psel_in && penable_in && pwrite_in &&
               paddr_in == `MSC_ADDR_CTRL;
  // Shadow of the completion flag, so that refusals can be predicted.
  always @(posedge mclk_in)
    if (!resetn_in) done_q <= 1'b0;
    else if (scan_end_in) done_q <= 1'b1;
    else if (wr_c && !pwdata_in[15]) done_q <= 1'b0;
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!resetn_in);
  sequence s_go;
    wr_c && pwdata_in[0] && !scan_busy_in && !done_q;
  endsequence
  sequence s_clash;
    wr_c && pwdata_in[0] && (scan_busy_in || done_q);
  endsequence
  req_start_a: assert property (s_go |=> scan_start_out)
    else $error("accepted request gave no start");
  req_reject_a: assert property (s_clash |=>
    request_rejected_alert_out && !scan_start_out)
    else $error("clashing request not refused");
  cfg_only_a: assert property (wr_c && !pwdata_in[0] |=>
    data_transfer_out && !scan_start_out)
    else $error("plain write misbehaved");
  strobe_zero_a: assert property (psel_in && penable_in &&
    !pwrite_in && paddr_in == `MSC_ADDR_CTRL |-> !prdata_out[0])
    else $error("request bit read as one");
  bal_type_a: assert property (balance_scan_in |=>
    eff_type_out == `MSC_TYPE_ADC) else $error("balance type wrong");
  bal_ovs_a: assert property (balance_scan_in |=>
    eff_ovs_out == `MSC_OVS_BALANCE) else $error("balance ovs wrong");
  bal_order_a: assert property (balance_scan_in |=> !eff_ramp_out)
    else $error("balance order wrong");
  comp_order_a: assert property (eff_type_out inside
    {3'h1, 3'h2, 3'h3} |-> !eff_ramp_out) else $error("ramp not ignored");
  amend_src_a: assert property (amend_strobe_out |->
    $past(scan_end_in)) else $error("amend without scan end");
endmodule // msc_asserts
bind msc_scan_control msc_asserts u_chk (.mclk_in, .resetn_in, .psel_in,
  .penable_in, .pwrite_in, .paddr_in, .pwdata_in, .prdata_out,
  .scan_busy_in, .scan_end_in, .balance_scan_in, .scan_start_out,
  .request_rejected_alert_out, .data_transfer_out, .eff_ramp_out,
  .amend_strobe_out, .eff_type_out, .eff_ovs_out);

/* verification/tb_measurement_scan_control.sv */
`include "msc_defines.vh"
module tb_measurement_scan_control;
  timeunit 1ns;
  timeprecision 100ps;
  logic        mclk_in = 1'b0, resetn_in = 1'b0, psel_in = 1'b0;
  logic        penable_in = 1'b0, pwrite_in = 1'b0, scan_busy_in = 1'b0;
  logic        scan_end_in = 1'b0, scan_timeout_in = 1'b0;
  logic        data_moved_in = 1'b0, balance_scan_in = 1'b0;
  logic [11:0] paddr_in = 12'h000;
  logic [31:0] pwdata_in = 32'h0, rd;
  logic        st, rj, er, am, dt;
  wire         data_transfer_out, eff_alt_path_out, eff_amend_out;
  wire         comp_unipolar_out, cal_only_out, alert_filt_out;
  wire         autobal_dis_out;
  wire  [2:0]  eff_type_out, eff_ovs_out;
  wire  [31:0] prdata_out;
  wire         pready_out, pslverr_out, scan_start_out, eff_ramp_out;
  wire         amend_strobe_out, read_filtered_select_latched_out, read_filtered_select_live_out;
  wire         request_rejected_alert_out;
  int          fail_count = 0, num_checks = 0, cyc = 0;
  msc_scan_control dut_u (
    .mclk_in, .resetn_in, .psel_in, .penable_in, .pwrite_in, .paddr_in,
    .pwdata_in, .pready_out, .prdata_out, .pslverr_out, .scan_busy_in,
    .scan_end_in, .scan_timeout_in, .data_moved_in, .balance_scan_in,
    .scan_start_out, .data_transfer_out, .eff_type_out, .eff_ovs_out,
    .eff_alt_path_out, .eff_ramp_out, .eff_amend_out,
    .amend_strobe_out, .comp_unipolar_out, .cal_only_out,
    .read_filtered_select_latched_out, .read_filtered_select_live_out, .alert_filt_out,
    .autobal_dis_out, .request_rejected_alert_out);
  ////////////////////////////////////////////////////////////////////////
  initial forever #2.5 mclk_in = ~mclk_in;
  always @(posedge mclk_in) begin
    cyc++;
    if (cyc == 2000) begin
      fail_count++;
      test_done;
    end
  end
  task chk(input string n, input logic [31:0] g, input logic [31:0] e);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task test_done;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge mclk_in) penable_in <= 1'b1;
    do @(posedge mclk_in); while (pready_out !== 1'b1);
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    #1 st = scan_start_out;
    rj = request_rejected_alert_out;
    dt = data_transfer_out;
  endtask
  task wr(input logic [31:0] d); apb(1'b1, `MSC_ADDR_CTRL, d); endtask
  task rdc(input logic [31:0] e);
    apb(1'b0, `MSC_ADDR_CTRL, 32'h0);
    chk("ctrl", rd, e);
  endtask
  task end_scan;
    @(posedge mclk_in) scan_end_in <= 1'b1;
    @(posedge mclk_in) scan_end_in <= 1'b0;
    #1 am = amend_strobe_out;
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(posedge mclk_in);
    resetn_in <= 1'b1;
    rdc(32'h0);
    wr(32'h1ffe);
    chk("start", st, 0);
    chk("xfer", dt, 1);
    chk("autobal", autobal_dis_out, 1);
    rdc(32'h1ffe);
    for (int t = 0; t < 8; t++) begin
      wr(32'(t * 72 + 6));
      @(posedge mclk_in);
      #1 chk("type", eff_type_out, t);
      chk("ovs", eff_ovs_out, t == 3 ? 0 : t);
      chk("ramp", eff_ramp_out, t inside {[1:3]} ? 0 : 1);
      chk("unipolar", comp_unipolar_out, t inside {[1:2]});
      chk("calonly", cal_only_out, t == 3);
      chk("altpath", eff_alt_path_out, t < 4);
      chk("effamend", eff_amend_out, 0);
    end
    @(posedge mclk_in) balance_scan_in <= 1'b1;
    @(posedge mclk_in);
    #1 chk("btype", {eff_type_out, eff_ovs_out, eff_ramp_out}, 7'h06);
    chk("bamend", eff_amend_out, 1);
    chk("balfilt", alert_filt_out, 1);
    wr(32'h1);
    chk("start", st, 1);
    end_scan;
    chk("amend", am, 1);
    @(posedge mclk_in) balance_scan_in <= 1'b0;
    rdc(32'h8000);
    wr(32'h8283);
    chk("reject", {rj, st}, 2'b10);
    rdc(32'h8282);
    wr(32'h0);
    rdc(32'h0);
    wr(32'h0601);
    end_scan;
    chk("amend", am, 1);
    wr(32'h0);
    chk("filt", {read_filtered_select_latched_out, read_filtered_select_live_out}, 2'b10);
    wr(32'h1);
    end_scan;
    chk("amend", am, 0);
    wr(32'h0);
    @(posedge mclk_in) scan_busy_in <= 1'b1;
    wr(32'h1);
    chk("reject", {rj, st}, 2'b10);
    @(posedge mclk_in) scan_busy_in <= 1'b0;
    @(posedge mclk_in) {scan_timeout_in, data_moved_in} <= 2'b11;
    @(posedge mclk_in) {scan_timeout_in, data_moved_in} <= 2'b00;
    wr(32'h6000);
    rdc(32'h6000);
    wr(32'h0);
    rdc(32'h0);
    wr(32'h0104);
    @(posedge mclk_in);
    #1 chk("diagpath", eff_alt_path_out, 0);
    wr(32'h0105);
    chk("diagstart", {st, dt}, 2'b11);
    apb(1'b0, 12'h070, 32'h0);
    chk("unmapped", {er, rd}, 33'h100000000);
    test_done;
  end
endmodule // tb_measurement_scan_control
